/* design/i2c_crc_slave.sv */
// i2c register slave with plain and crc protected frame types
`timescale 1ns/100ps
module i2c_crc_slave (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // i2c pins, sda is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // byte memory, read data is combinational from mem_addr
    output logic [7:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic mem_we,
    output logic [7:0] mem_waddr,
    output logic [7:0] mem_wdata,
    // measurement words
    input wire logic [15:0] temp_word,
    input wire logic [15:0] press_word,
    input wire logic [15:0] status_word,
    // checksum error event
    input wire logic crc_err_clr,
    output logic crc_err
);
    import i2c_crc_pkg::*;

    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    i2c_crc_pkg::state_t st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic oe_q, ack_q;
    logic [1:0] bidx_q;
    logic crcm_q, rw_q, hbad_q;
    logic [4:0] dcnt_q;
    logic [3:0] len_q;
    logic [7:0] base_q, ptr_q;
    logic [2:0] cmt_q;
    logic [1:0] widx_q;
    logic [7:0] wbuf_q [4];
    logic we_q;
    logic [7:0] waddr_q, wdata_q;
    logic [3:0] crc4_q;
    logic [7:0] crc8_q;
    logic err_q;

    // pins pass three flops; the first stage feeds nothing but the second
    always_ff @(posedge clock) begin
        if (!resetn) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    // bus events seen on the synchronised levels
    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;
    wire scl_high = scl_s_q & scl_p_q;
    wire start_c = scl_high & sda_p_q & ~sda_s_q;
    wire stop_c = scl_high & ~sda_p_q & sda_s_q;

    // byte decode at the eighth data bit
    wire [7:0] bval = {sh_q[6:0], sda_s_q};
    wire byte_done = (st_q == ST_RX) & scl_rise & (bit_q == 4'h7);
    wire addr_hit = bval[7:2] == SLAVE_ADDR[6:1];
    wire is_addr = byte_done & (bidx_q == 2'h0);
    wire is_mem = byte_done & (bidx_q == 2'h1);
    wire is_len = byte_done & (bidx_q == 2'h2) & crcm_q;
    wire is_data = byte_done &
                   ((bidx_q == 2'h3) | ((bidx_q == 2'h2) & ~crcm_q));
    wire tx_load = (st_q == ST_ACK) & scl_fall & rw_q;

    // length field counts bytes minus one
    wire [4:0] lenp1 = {1'b0, len_q} + 5'h01;
    wire in_data = dcnt_q < lenp1;
    wire at_crc = dcnt_q == lenp1;
    wire crc4_bad = bval[3:0] != crc4_q;
    wire crc8_bad = bval != crc8_q;
    wire crc_byte = is_data & crcm_q & at_crc;
    wire err_set = (is_len & crc4_bad) | (crc_byte & crc8_bad);
    // a protected write lands only with both checksums good
    wire commit_go = crc_byte & ~crc8_bad & ~hbad_q &
                     (len_q < WR_MAX_BYTES);
    wire buf_wr = is_data & crcm_q & in_data &
                  (dcnt_q < {1'b0, WR_MAX_BYTES});

    // measurement words overlay the byte memory, low byte at even address
    wire hit_t = ptr_q[7:1] == ADDR_TEMP[7:1];
    wire hit_p = ptr_q[7:1] == ADDR_PRESS[7:1];
    wire hit_s = ptr_q[7:1] == ADDR_STATUS[7:1];
    wire [15:0] rd_word = hit_t ? temp_word :
                          (hit_p ? press_word : status_word);
    // odd start addresses are not guarded, they just read the high byte
    wire [7:0] rd_byte = ~(hit_t | hit_p | hit_s) ? mem_rdata :
                         (ptr_q[0] ? rd_word[15:8] : rd_word[7:0]);
    wire [7:0] tx_data = (~crcm_q | in_data) ? rd_byte :
                         (at_crc ? crc8_q : IDLE_BYTE);

    // checksum enables, bit for bit as on the wire; the header check starts
    // at the memory address, the slave address byte is left out of it
    wire c4_en = (st_q == ST_RX) & scl_rise &
                 ((bidx_q == 2'h1) | ((bidx_q == 2'h2) & ~bit_q[2]));
    wire c8_rx = (st_q == ST_RX) & scl_rise & crcm_q & ~rw_q &
                 (bidx_q == 2'h3) & in_data;
    wire c8_tx = (st_q == ST_TX) & scl_rise & crcm_q & (dcnt_q <= lenp1);

    // bit engine; a start in any state restarts the frame
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            oe_q <= 1'b0;
            ack_q <= 1'b0;
        end else if (start_c) begin
            st_q <= ST_RX;
            bit_q <= 4'h0;
            oe_q <= 1'b0;
        end else if (stop_c) begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
        end else begin
            case (st_q)
                ST_RX: if (scl_rise) begin
                    sh_q <= bval;
                    bit_q <= bit_q + 4'h1;
                    if (bit_q == 4'h7) begin
                        st_q <= ST_RXD;
                        ack_q <= (bidx_q != 2'h0) | addr_hit;
                    end
                end
                ST_RXD: if (scl_fall) begin
                    oe_q <= ack_q;
                    st_q <= ack_q ? ST_ACK : ST_IDLE;
                end
                ST_ACK: if (scl_fall) begin
                    bit_q <= 4'h0;
                    if (rw_q) begin
                        sh_q <= tx_data;
                        oe_q <= ~tx_data[7];
                        st_q <= ST_TX;
                    end else begin
                        oe_q <= 1'b0;
                        st_q <= ST_RX;
                    end
                end
                ST_TX: if (scl_rise) begin
                    bit_q <= bit_q + 4'h1;
                end else if (scl_fall) begin
                    if (bit_q == 4'h8) begin
                        oe_q <= 1'b0;
                        st_q <= ST_MACK;
                    end else begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        oe_q <= ~sh_q[6];
                    end
                end
                // master nack ends the read, ack fetches the next byte
                ST_MACK: if (scl_rise) begin
                    st_q <= sda_s_q ? ST_IDLE : ST_ACK;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // frame decode, address pointer and memory writes
    always_ff @(posedge clock) begin
        if (!resetn) begin
            bidx_q <= 2'h0;
            crcm_q <= 1'b0;
            rw_q <= 1'b0;
            hbad_q <= 1'b0;
            dcnt_q <= 5'h00;
            len_q <= 4'h0;
            base_q <= 8'h00;
            ptr_q <= 8'h00;
            cmt_q <= 3'h0;
            widx_q <= 2'h0;
            we_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 8'h00;
        end else begin
            we_q <= 1'b0;
            if (start_c) begin
                bidx_q <= 2'h0;
                hbad_q <= 1'b0;
                dcnt_q <= 5'h00;
            end
            if (is_addr & addr_hit) begin
                crcm_q <= bval[1];
                rw_q <= bval[0];
                bidx_q <= 2'h1;
                dcnt_q <= 5'h00;
                if (bval[0]) begin
                    ptr_q <= base_q;
                end
            end
            if (is_mem) begin
                base_q <= bval;
                ptr_q <= bval;
                bidx_q <= 2'h2;
            end
            if (is_len) begin
                len_q <= bval[7:4];
                hbad_q <= crc4_bad;
                bidx_q <= 2'h3;
            end
            // plain write goes straight out and never runs out of room
            if (is_data & ~crcm_q) begin
                we_q <= 1'b1;
                waddr_q <= ptr_q;
                wdata_q <= bval;
                ptr_q <= ptr_q + 8'h01;
            end
            if (is_data & crcm_q & (dcnt_q <= lenp1)) begin
                dcnt_q <= dcnt_q + 5'h01;
            end
            if (commit_go) begin
                cmt_q <= {1'b0, len_q[1:0]} + 3'h1;
                widx_q <= 2'h0;
            end
            // read pointer advances with every data byte handed out
            if (tx_load) begin
                if (~crcm_q | in_data) begin
                    ptr_q <= ptr_q + 8'h01;
                end
                if (crcm_q & (dcnt_q <= lenp1)) begin
                    dcnt_q <= dcnt_q + 5'h01;
                end
            end
            // buffered write drains one byte a clock, starting right after the crc byte's eighth bit is sampled
            if (cmt_q != 3'h0) begin
                we_q <= 1'b1;
                waddr_q <= ptr_q;
                wdata_q <= wbuf_q[widx_q];
                ptr_q <= ptr_q + 8'h01;
                widx_q <= widx_q + 2'h1;
                cmt_q <= cmt_q - 3'h1;
            end
        end
    end

    // protected write data waits here until its crc8 is checked
    always_ff @(posedge clock) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                wbuf_q[i] <= 8'h00;
            end
        end else if (buf_wr) begin
            wbuf_q[dcnt_q[1:0]] <= bval;
        end
    end

    // checksums run serially over the bits as they pass scl high
    always_ff @(posedge clock) begin
        if (!resetn) begin
            crc4_q <= CRC4_INIT;
            crc8_q <= CRC8_INIT;
        end else if (start_c) begin
            crc4_q <= CRC4_INIT;
            crc8_q <= CRC8_INIT;
        end else begin
            if (c4_en) begin
                crc4_q <= crc4_step(crc4_q, sda_s_q);
            end
            if (c8_rx | c8_tx) begin
                crc8_q <= crc8_step(crc8_q, sda_s_q);
            end
        end
    end

    // sticky error event; a new error in the clear cycle survives
    always_ff @(posedge clock) begin
        if (!resetn) begin
            err_q <= 1'b0;
        end else if (err_set) begin
            err_q <= 1'b1;
        end else if (crc_err_clr) begin
            err_q <= 1'b0;
        end
    end

    // outputs; sda only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = oe_q;
    assign mem_addr = ptr_q;
    assign mem_we = we_q;
    assign mem_waddr = waddr_q;
    assign mem_wdata = wdata_q;
    assign crc_err = err_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    AST_ERR_STICKY: assert property (
        err_q & ~crc_err_clr |=> err_q)
        else $error("crc error flag dropped without clear");
    AST_ERR_SET_WINS: assert property (
        err_set & crc_err_clr |=> err_q)
        else $error("crc error lost in clear cycle");
    AST_ADDR_MISS_NACK: assert property (
        is_addr & ~addr_hit |=> ~ack_q ##1 ~oe_q)
        else $error("foreign slave address acknowledged");
    AST_MODE_FROM_LSB: assert property (
        is_addr & addr_hit |=> crcm_q == $past(bval[1]))
        else $error("frame type not taken from address lsb");
    AST_BASE_SET: assert property (
        is_mem |=> (base_q == $past(bval)) && (ptr_q == $past(bval)))
        else $error("memory address byte not loaded");
    AST_READ_LAST: assert property (
        is_addr & addr_hit & bval[0] |=> ptr_q == $past(base_q))
        else $error("read does not resume at last address");
    AST_PLAIN_WRITE: assert property (
        is_data & ~crcm_q |=> we_q && (waddr_q == $past(ptr_q)) &&
            (wdata_q == $past(bval)) && (ptr_q == $past(ptr_q) + 8'h01))
        else $error("plain write byte not stored in place");
    AST_TX_MSB_FIRST: assert property (
        (st_q == ST_TX) & scl_s_q |-> oe_q == ~sh_q[7])
        else $error("transmit bit is not the byte msb");
    AST_CRC_TAIL: assert property (
        tx_load & crcm_q & at_crc |=> sh_q == $past(crc8_q))
        else $error("protected read tail is not crc8");
    AST_CRC_INIT: assert property (
        start_c |=> (crc4_q == CRC4_INIT) && (crc8_q == CRC8_INIT))
        else $error("checksums not restarted at start");
    AST_BAD_NO_COMMIT: assert property (
        crc_byte & crc8_bad |=> err_q && (cmt_q == 3'h0))
        else $error("write with bad crc8 committed");
    AST_HDR_BAD_FLAG: assert property (
        is_len & crc4_bad |=> err_q && hbad_q)
        else $error("bad header checksum not flagged");

    COV_CRC_WRITE: cover property (commit_go ##[1:8] we_q);
    COV_CRC_READ: cover property (tx_load & crcm_q & at_crc);
    COV_CRC_ERR: cover property (err_set);
    COV_READ_LAST: cover property (is_addr & addr_hit & bval[0] & ~rw_q);

endmodule

/* design/i2c_crc_pkg.sv */
// constants, types and crc helpers for the crc-protected i2c register slave
// Overview of operation
// - random write stores bytes from given address
// - random read returns bytes from given address
// - read without address resumes at last address
// - slave address lsb selects frame type
// - even address plain, odd address crc protected
// - frame types mix freely, handled per address
// - memory address byte is first byte location
// - msb first, low byte before high byte
// - length nibble holds byte count minus one
// - crc read max 16, write max 4
// - plain frames run on without limit
// - checksums follow bus bit and byte order
// - crc4 polynomial 0x03, start value 0x0f
// - crc8 polynomial 0xd5, start value 0xff
// - checksum mismatch sets crc error event bit
// - default addresses 0x6c plain, 0x6d crc
// - bytes from 0x2e give temperature, pressure, status
package i2c_crc_pkg;

    // even slave address, the odd one is the next address
    localparam logic [6:0] SLAVE_ADDR = 7'h6c;

    // checksum generators and start values
    localparam logic [3:0] CRC4_POLY = 4'h3;
    localparam logic [3:0] CRC4_INIT = 4'hf;
    localparam logic [7:0] CRC8_POLY = 8'hd5;
    localparam logic [7:0] CRC8_INIT = 8'hff;

    // measurement words mapped into the byte space
    localparam logic [7:0] ADDR_TEMP = 8'h2e;
    localparam logic [7:0] ADDR_PRESS = 8'h30;
    localparam logic [7:0] ADDR_STATUS = 8'h32;

    // largest protected write, and filler after a protected read
    localparam logic [3:0] WR_MAX_BYTES = 4'h4;
    localparam logic [7:0] IDLE_BYTE = 8'hff;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RX = 6'h02,
        ST_RXD = 6'h04,
        ST_ACK = 6'h08,
        ST_TX = 6'h10,
        ST_MACK = 6'h20
    } state_t;

    // one serial step of the 4-bit checksum
    function automatic logic [3:0] crc4_step(input logic [3:0] c,
                                             input logic b);
        crc4_step = {c[2:0], 1'b0} ^ ((c[3] ^ b) ? CRC4_POLY : 4'h0);
    endfunction

    // one serial step of the 8-bit checksum
    function automatic logic [7:0] crc8_step(input logic [7:0] c,
                                             input logic b);
        crc8_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC8_POLY : 8'h00);
    endfunction

endpackage

/* sim/i2c_master_model.sv */
// behavioural i2c master driving the slave's bus pins
`timescale 1ns/100ps
module i2c_master_model (
    // bus lines, data is open drain with a pull-up
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // idle bus: clock stands high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // start or repeated start: data released first, then falls with scl high
    task automatic start();
        #35 sda_pull = 1'b0;
        #35 scl = 1'b1;
        #55 sda_pull = 1'b1;
        #35 scl = 1'b0;
    endtask
    // stop: data rises while scl high, clock then stands still
    task automatic stop();
        #35 sda_pull = 1'b1;
        #35 scl = 1'b1;
        #55 sda_pull = 1'b0;
        #35;
    endtask
    // data changes mid-low, well after the slave has seen scl fall
    task automatic bit_out(input logic b);
        #35 sda_pull = ~b;
        #35 scl = 1'b1;
        #55 scl = 1'b0;
    endtask
    task automatic bit_in(output logic b);
        #35 sda_pull = 1'b0;
        #35 scl = 1'b1;
        #30 b = sda;
        #25 scl = 1'b0;
    endtask
    // byte out, then the slave's acknowledge (1 means refused)
    task automatic wr_byte(input logic [7:0] d, output logic nack);
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(nack);
    endtask
    // byte in, then our acknowledge; last byte gets a nack
    task automatic rd_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(last);
    endtask
endmodule

/* sim/i2c_crc_slave_tb_top.sv */
// self-checking bench for the crc-protected i2c register slave
`timescale 1ns/100ps
module i2c_crc_slave_tb_top;
    import i2c_crc_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic crc_err_clr = 1'b0;
    logic [15:0] temp_word = 16'h7df2;
    logic [15:0] press_word = 16'h82ea;
    logic [15:0] status_word = 16'h001e;
    logic [7:0] mem [256];
    logic scl, pull, sda_o, sda_oe, mem_we, crc_err;
    logic [7:0] mem_addr, mem_waddr, mem_wdata, mem_rdata;
    wire sda = ~(pull | (sda_oe & ~sda_o));
    int fail_count = 0;
    int cmp_count = 0;

    always #4 clock = ~clock;
    // byte memory: combinational read, write port as the slave drives it
    assign mem_rdata = mem[mem_addr];
    always @(posedge clock) if (mem_we) mem[mem_waddr] <= mem_wdata;

    i2c_master_model m (.scl(scl), .sda_pull(pull), .sda(sda));
    i2c_crc_slave dut (.clock(clock), .resetn(resetn), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr),
        .mem_wdata(mem_wdata), .temp_word(temp_word),
        .press_word(press_word), .status_word(status_word),
        .crc_err_clr(crc_err_clr), .crc_err(crc_err));

    // serial checksums in bus order, written apart from the design's own
    function automatic logic [3:0] c4(logic [3:0] c, logic [7:0] b, int n);
        for (int i = 7; i > 7 - n; i--) begin
            c = {c[2:0], 1'b0} ^ ((c[3] ^ b[i]) ? 4'h3 : 4'h0);
        end
        return c;
    endfunction
    function automatic logic [7:0] c8(logic [7:0] c, logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'hd5 : 8'h00);
        end
        return c;
    endfunction

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] d);
        logic n;
        m.wr_byte(d, n);
        chk("ack", 16'h0000, {15'h0000, n});
    endtask
    task automatic rd(logic [7:0] exp, logic last);
        logic [7:0] d;
        m.rd_byte(last, d);
        chk("rdata", {8'h00, exp}, {8'h00, d});
    endtask

    // unprotected write of two words, runs past one word without limit
    task automatic t_plain_write();
        logic [7:0] dat [4] = '{8'h32, 8'h6c, 8'h11, 8'h44};
        m.start();
        wr(8'hd8);
        wr(8'h22);
        for (int i = 0; i < 4; i++) wr(dat[i]);
        m.stop();
        repeat (4) @(negedge clock);
        for (int i = 0; i < 4; i++) begin
            chk("mem", {8'h00, dat[i]}, {8'h00, mem[8'h22 + i]});
        end
        $display("test plain_write done");
    endtask
    // address, repeated start, then measurements and on into memory
    task automatic t_plain_read();
        logic [7:0] e [8] = '{temp_word[7:0], temp_word[15:8], press_word[7:0],
            press_word[15:8], status_word[7:0], status_word[15:8], 8'h34, 8'h35};
        m.start();
        wr(8'hd8);
        wr(ADDR_TEMP);
        m.start();
        wr(8'hd9);
        for (int i = 0; i < 8; i++) rd(e[i], i == 7);
        m.stop();
        $display("test plain_read done");
    endtask
    // pointer has moved on, read-last must go back to the address set
    task automatic t_read_last();
        m.start();
        wr(8'hd9);
        rd(temp_word[7:0], 1'b0);
        rd(temp_word[15:8], 1'b1);
        m.stop();
        $display("test read_last done");
    endtask
    // protected read mixed after plain frames, device appends its crc8
    task automatic t_crc_read();
        logic [7:0] e [7] = '{temp_word[7:0], temp_word[15:8], press_word[7:0],
            press_word[15:8], status_word[7:0], status_word[15:8], 8'h00};
        logic [7:0] k;
        k = 8'hff;
        for (int i = 0; i < 6; i++) k = c8(k, e[i]);
        e[6] = k;
        m.start();
        wr(8'hda);
        wr(8'h2e);
        wr(8'h5b);
        m.start();
        wr(8'hdb);
        for (int i = 0; i < 7; i++) rd(e[i], i == 6);
        m.stop();
        chk("crc_err", 16'h0000, {15'h0000, crc_err});
        $display("test crc_read done");
    endtask
    // protected write; a spoiled crc4 or crc8 drops the data, raises the event
    task automatic t_crc_write(logic [7:0] a, logic bad, logic bad4);
        logic [3:0] h;
        logic [7:0] k;
        logic sp;
        logic [7:0] lo;
        logic [7:0] hi;
        sp = bad | bad4;
        lo = sp ? a : 8'ha1;
        hi = sp ? a + 8'h01 : 8'h5e;
        // header check spans the memory address and the length nibble only
        h = c4(c4(4'hf, a, 8), 8'h10, 4);
        k = c8(c8(8'hff, 8'ha1), 8'h5e);
        m.start();
        wr(8'hda);
        wr(a);
        wr({4'h1, h ^ {3'h0, bad4}});
        wr(8'ha1);
        wr(8'h5e);
        wr(k ^ {7'h00, bad});
        m.stop();
        repeat (4) @(negedge clock);
        chk("crc_err", {15'h0000, sp}, {15'h0000, crc_err});
        chk("mem", {8'h00, lo}, {8'h00, mem[a]});
        chk("mem", {8'h00, hi}, {8'h00, mem[a + 8'h01]});
        if (sp) begin
            crc_err_clr = 1'b1;
            @(negedge clock);
            crc_err_clr = 1'b0;
            @(negedge clock);
            chk("crc_err", 16'h0000, {15'h0000, crc_err});
        end
        $display("test crc_write done");
    endtask
    // a foreign slave address is refused
    task automatic t_refuse();
        logic n;
        m.start();
        m.wr_byte(8'ha0, n);
        m.stop();
        chk("nack", 16'h0001, {15'h0000, n});
        $display("test refuse done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 256; i++) mem[i] = i[7:0];
        repeat (8) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        t_plain_write();
        t_plain_read();
        t_read_last();
        t_crc_read();
        t_crc_write(8'h40, 1'b0, 1'b0);
        t_crc_write(8'h44, 1'b1, 1'b0);
        t_crc_write(8'h48, 1'b0, 1'b1);
        t_refuse();
        complete_run();
    end
    // about 50 bytes of 1.1 us each are expected; allow about nine times that
    initial begin
        #500000;
        fail_count++;
        complete_run();
    end
endmodule
